// *** core/nsc_pkg.sv ***
package nsc_pkg;

  // i/o port addresses
  localparam logic [15:0] NSC_STATUS_ADDR = 16'h0061;
  localparam logic [15:0] NSC_MASK_ADDR   = 16'h0070;

  // field positions in the status/control register
  localparam int NSC_BIT_PERR    = 7;
  localparam int NSC_BIT_IOCHK   = 6;
  localparam int NSC_BIT_SPKOUT  = 5;
  localparam int NSC_BIT_REFRESH = 4;
  localparam int NSC_BIT_CHK_DIS = 3;
  localparam int NSC_BIT_ERR_DIS = 2;
  localparam int NSC_BIT_SPK_EN  = 1;
  localparam int NSC_BIT_GATE    = 0;

  // mask port fields
  localparam int NSC_BIT_NMI_MASK = 7;
  localparam int NSC_RTC_W        = 7;

  // values after reset
  localparam logic [3:0] NSC_CTRL_RST   = 4'h0;
  localparam logic       NSC_MASK_RST   = 1'b0;
  localparam logic [6:0] NSC_RTC_RST    = 7'h00;
  localparam logic [7:0] NSC_RDATA_RST  = 8'h00;
  localparam logic [7:0] NSC_UNMAPPED_RD = 8'h00;
  localparam logic       NSC_PIN_IDLE    = 1'h1;
  localparam logic       NSC_FLAG_RST    = 1'h0;

  // one i/o cycle request from the host side
  typedef struct packed {
    logic        rd;     // read strobe, one cycle
    logic        wr;     // write strobe, one cycle
    logic [15:0] addr;   // i/o port address
    logic [7:0]  wdata;  // write data
  } nsc_io_req_s;

endpackage : nsc_pkg

// *** core/nsc_nmi_status.sv ***
`timescale 1ns/100ps
module nsc_nmi_status
  import nsc_pkg::*;
(
  input  wire logic        clk_in,        // 100 MHz system clock
  input  wire logic        resetn_in,     // async reset, low active
  input  wire nsc_io_req_s io_req_in,     // i/o cycle request
  output logic       [7:0] io_rdata_out,  // read data
  output logic             io_rvalid_out, // read data valid pulse
  input  wire logic        perr_n_in,     // board parity error pin
  input  wire logic        iochk_n_in,    // channel check pin
  input  wire logic        serr_nmi_in,   // system error nmi, gated upstream
  input  wire logic        spk_cnt_in,    // speaker counter output
  input  wire logic        refresh_in,    // refresh cycle done pulse
  output logic             spk_gate_out,  // speaker counter gate
  output logic             speaker_out,   // speaker pin
  output logic             nmi_out,       // nmi request
  output logic       [6:0] rtc_addr_out   // clock memory address
);

  // register state
  logic       gate_q;
  logic       gate_d;
  logic       spk_en_q;
  logic       spk_en_d;
  logic       err_dis_q;
  logic       err_dis_d;
  logic       chk_dis_q;
  logic       chk_dis_d;
  logic       perr_st_q;
  logic       perr_st_d;
  logic       chk_st_q;
  logic       chk_st_d;
  logic       refr_q;
  logic       refr_d;
  logic       mask_q;
  logic       mask_d;
  logic [6:0] rtc_q;
  logic [6:0] rtc_d;
  logic [7:0] rdata_q;
  logic       rvalid_q;
  logic       spk_q;
  logic       nmi_q;

  // pin synchronisers and edge history
  logic       perr_s1_q;
  logic       perr_s2_q;
  logic       perr_s3_q;
  logic       chk_s1_q;
  logic       chk_s2_q;

  // address decode
  wire hit_status = (io_req_in.addr == NSC_STATUS_ADDR);
  wire hit_mask   = (io_req_in.addr == NSC_MASK_ADDR);

  // strobes qualified per port, except rd_any which takes every read
  wire wr_status  = io_req_in.wr & hit_status;
  wire wr_mask    = io_req_in.wr & hit_mask;
  wire rd_status  = io_req_in.rd & hit_status;
  wire rd_any     = io_req_in.rd;

  // write data fields, upper status bits never stored
  wire       wr_gate   = io_req_in.wdata[NSC_BIT_GATE];
  wire       wr_spk_en = io_req_in.wdata[NSC_BIT_SPK_EN];
  wire       wr_err    = io_req_in.wdata[NSC_BIT_ERR_DIS];
  wire       wr_chk    = io_req_in.wdata[NSC_BIT_CHK_DIS];
  wire       wr_nmask  = io_req_in.wdata[NSC_BIT_NMI_MASK];
  wire [6:0] wr_rtc    = io_req_in.wdata[NSC_RTC_W-1:0];

  // synchroniser taps seen by the logic
  wire perr_sync  = perr_s2_q;
  wire perr_prev  = perr_s3_q;
  wire chk_sync   = chk_s2_q;

  // source events after synchronisation
  wire perr_pulse = perr_prev & ~perr_sync;  // falling pin edge
  wire chk_level  = ~chk_sync;               // pin held low

  // status set and clear terms
  wire perr_set   = perr_pulse;
  wire perr_clr   = err_dis_q;
  wire chk_set    = chk_level;
  wire chk_clr    = chk_dis_q;

  // control bits: only the low nibble is stored
  assign gate_d    = wr_status ? wr_gate : gate_q;
  assign spk_en_d  = wr_status ? wr_spk_en : spk_en_q;
  assign err_dis_d = wr_status ? wr_err : err_dis_q;
  assign chk_dis_d = wr_status ? wr_chk : chk_dis_q;

  // board error status: set on pulse when enabled, held clear when disabled
  assign perr_st_d = perr_clr ? 1'h0 :
                     (perr_st_q | perr_set);

  // channel check status
  assign chk_st_d = chk_clr ? 1'h0 :
                    (chk_st_q | chk_set);

  // refresh toggle
  assign refr_d = refresh_in ? ~refr_q : refr_q;

  // mask port, write only
  assign mask_d = wr_mask ? wr_nmask : mask_q;
  assign rtc_d  = wr_mask ? wr_rtc : rtc_q;

  // read value, speaker counter taken live
  wire [3:0] ctrl_rd   = {chk_dis_q, err_dis_q, spk_en_q, gate_q};
  wire [7:0] status_rd = {perr_st_q,
                          chk_st_q,
                          spk_cnt_in,
                          refr_q,
                          ctrl_rd};

  // unmapped and write-only ports read as zero
  wire [7:0] rdata_d = rd_status ? status_rd : NSC_UNMAPPED_RD;

  // any read is answered
  wire rvalid_d = rd_any;

  // per-source nmi terms
  wire nmi_perr = perr_st_q & ~err_dis_q;
  wire nmi_chk  = chk_st_q & ~chk_dis_q;
  wire nmi_serr = serr_nmi_in;

  // enabled sources qualified by the global mask
  wire nmi_src = nmi_perr | nmi_chk | nmi_serr;
  wire nmi_d   = nmi_src & ~mask_q;

  // speaker pin next value
  wire spk_d   = spk_en_q & spk_cnt_in;

  // board error pin, first stage
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      perr_s1_q <= NSC_PIN_IDLE;
    end else begin
      perr_s1_q <= perr_n_in;
    end
  end

  // board error pin, second stage
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      perr_s2_q <= NSC_PIN_IDLE;
    end else begin
      perr_s2_q <= perr_s1_q;
    end
  end

  // board error edge history
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      perr_s3_q <= NSC_PIN_IDLE;
    end else begin
      perr_s3_q <= perr_s2_q;
    end
  end

  // channel check pin, first stage
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      chk_s1_q <= NSC_PIN_IDLE;
    end else begin
      chk_s1_q <= iochk_n_in;
    end
  end

  // channel check pin, second stage
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      chk_s2_q <= NSC_PIN_IDLE;
    end else begin
      chk_s2_q <= chk_s1_q;
    end
  end

  // counter gate bit
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gate_q <= NSC_CTRL_RST[NSC_BIT_GATE];
    end else begin
      gate_q <= gate_d;
    end
  end

  // speaker enable bit
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      spk_en_q <= NSC_CTRL_RST[NSC_BIT_SPK_EN];
    end else begin
      spk_en_q <= spk_en_d;
    end
  end

  // board error disable bit
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      err_dis_q <= NSC_CTRL_RST[NSC_BIT_ERR_DIS];
    end else begin
      err_dis_q <= err_dis_d;
    end
  end

  // channel check disable bit
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      chk_dis_q <= NSC_CTRL_RST[NSC_BIT_CHK_DIS];
    end else begin
      chk_dis_q <= chk_dis_d;
    end
  end

  // board error status
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      perr_st_q <= NSC_FLAG_RST;
    end else begin
      perr_st_q <= perr_st_d;
    end
  end

  // channel check status
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      chk_st_q <= NSC_FLAG_RST;
    end else begin
      chk_st_q <= chk_st_d;
    end
  end

  // refresh toggle bit
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      refr_q <= NSC_FLAG_RST;
    end else begin
      refr_q <= refr_d;
    end
  end

  // global nmi mask
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mask_q <= NSC_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // clock memory address
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rtc_q <= NSC_RTC_RST;
    end else begin
      rtc_q <= rtc_d;
    end
  end

  // read data
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_q <= NSC_RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // read answer strobe
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rvalid_q <= NSC_FLAG_RST;
    end else begin
      rvalid_q <= rvalid_d;
    end
  end

  // speaker pin flop
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      spk_q <= NSC_FLAG_RST;
    end else begin
      spk_q <= spk_d;
    end
  end

  // nmi request flop
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      nmi_q <= NSC_FLAG_RST;
    end else begin
      nmi_q <= nmi_d;
    end
  end

  // host side outputs
  assign io_rdata_out  = rdata_q;
  assign io_rvalid_out = rvalid_q;

  // speaker, nmi and clock address outputs
  assign spk_gate_out  = gate_q;
  assign speaker_out   = spk_q;
  assign nmi_out       = nmi_q;
  assign rtc_addr_out  = rtc_q;

endmodule : nsc_nmi_status

// *** tb/nsc_sva.sv ***
`timescale 1ns/100ps
module nsc_sva
  import nsc_pkg::*;
(
  input wire logic        clk_in,        // clock
  input wire logic        resetn_in,     // reset
  input wire nsc_io_req_s io_req_in,     // request
  input wire logic  [7:0] io_rdata_out,  // data
  input wire logic        io_rvalid_out, // answer
  input wire logic        spk_cnt_in,    // counter
  input wire logic        spk_gate_out,  // gate
  input wire logic        speaker_out,   // speaker
  input wire logic        nmi_out,       // nmi
  input wire logic  [6:0] rtc_addr_out   // address
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // port decodes
  wire st_wr = io_req_in.wr && io_req_in.addr == NSC_STATUS_ADDR;
  wire mk_wr = io_req_in.wr && io_req_in.addr == NSC_MASK_ADDR;
  wire st_rd = io_req_in.rd && io_req_in.addr == NSC_STATUS_ADDR;
  // read, control and mask checks
  a_rd_valid: assert property (io_req_in.rd |=> io_rvalid_out)
    else $error("read not answered");
  a_idle_quiet: assert property (!io_req_in.rd |=> !io_rvalid_out && !io_rdata_out)
    else $error("answer without read");
  a_rd_other: assert property (io_req_in.rd && !st_rd |=> io_rdata_out == 8'h00)
    else $error("other port read not zero");
  a_rd_live: assert property (st_rd |=> io_rdata_out[5] == $past(spk_cnt_in))
    else $error("counter bit not live");
  a_gate_write: assert property (st_wr |=> spk_gate_out == $past(io_req_in.wdata[0]))
    else $error("gate not bit zero");
  a_spk_off: assert property (st_wr && !io_req_in.wdata[1] |=> ##1 !speaker_out)
    else $error("speaker not gated");
  a_mask_blocks: assert property (mk_wr && io_req_in.wdata[7] |=> ##1 !nmi_out)
    else $error("nmi not masked");
  a_rtc_addr: assert property (mk_wr |=> rtc_addr_out == $past(io_req_in.wdata[6:0]))
    else $error("clock address wrong");
  c_status_rd: cover property (st_rd);
  c_mask_set: cover property (mk_wr && io_req_in.wdata[7]);
  c_nmi_rise: cover property ($rose(nmi_out));
endmodule : nsc_sva
bind nsc_nmi_status nsc_sva u_sva (.clk_in(clk_in), .resetn_in(resetn_in),
  .io_req_in(io_req_in), .io_rdata_out(io_rdata_out), .io_rvalid_out(io_rvalid_out),
  .spk_cnt_in(spk_cnt_in), .spk_gate_out(spk_gate_out), .speaker_out(speaker_out),
  .nmi_out(nmi_out), .rtc_addr_out(rtc_addr_out));

// *** tb/nsc_host.sv ***
`timescale 1ns/100ps
module nsc_host
  import nsc_pkg::*;
(
  input  wire logic       clk_in,    // clock
  input  wire logic [7:0] rdata_in,  // read data
  input  wire logic       rvalid_in, // read answer
  output nsc_io_req_s     req_out    // request
);
  // one i/o cycle, then an idle cycle
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    req_out = '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk_in);
    #1 req_out = '0;
    q = rvalid_in ? rdata_in : 8'hxx;
    @(posedge clk_in);
    #1;
  endtask : io
  initial req_out = '0;
endmodule : nsc_host

// *** tb/tb_nmi_status_speaker_control.sv ***
`timescale 1ns/100ps
module tb_nmi_status_speaker_control
  import nsc_pkg::*;
;
  logic clk_in = 1'b0, resetn_in = 1'b0, perr_n = 1'b1, iochk_n = 1'b1;
  logic serr = 1'b0, spk = 1'b0, refr = 1'b0, rvalid, gate, spko, nmi;
  logic [7:0] rdata, q;
  logic [6:0] rtc;
  nsc_io_req_s req;
  int miscompares = 0;
  int tests_run = 0;
  always #5 clk_in = ~clk_in;
  nsc_nmi_status dut (.clk_in(clk_in), .resetn_in(resetn_in), .io_req_in(req),
    .io_rdata_out(rdata), .io_rvalid_out(rvalid), .perr_n_in(perr_n), .iochk_n_in(iochk_n),
    .serr_nmi_in(serr), .spk_cnt_in(spk), .refresh_in(refr), .spk_gate_out(gate),
    .speaker_out(spko), .nmi_out(nmi), .rtc_addr_out(rtc));
  nsc_host host (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .req_out(req));
  // helpers
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(input int n); repeat (n) @(posedge clk_in); #1; endtask : cyc
  task automatic wr(input logic [15:0] a, input logic [7:0] d); host.io(1'b1, a, d, q); endtask : wr
  task automatic rs(input logic [7:0] e); host.io(1'b0, NSC_STATUS_ADDR, 8'h00, q); chk(q, e); endtask : rs
  task automatic summarize();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // scenarios
  task automatic t_ctrl();
    rs(NSC_RDATA_RST);
    chk({5'h00, gate, spko, nmi}, 8'h00);
    wr(NSC_STATUS_ADDR, 8'h03);
    spk = 1'b1;
    cyc(2);
    chk({6'h00, gate, spko}, 8'h03);
    rs(8'h23);
    wr(NSC_STATUS_ADDR, 8'h01);
    cyc(2);
    chk({6'h00, gate, spko}, 8'h02);
    spk = 1'b0;
    wr(NSC_STATUS_ADDR, 8'h00);
    host.io(1'b0, NSC_MASK_ADDR, 8'h00, q);
    chk(q, NSC_UNMAPPED_RD);
  endtask : t_ctrl
  task automatic t_perr();
    wr(NSC_MASK_ADDR, 8'h05);
    perr_n = 1'b0; cyc(1); perr_n = 1'b1; cyc(4);
    rs(8'h80);
    chk({nmi, rtc}, 8'h85);
    wr(NSC_MASK_ADDR, 8'h80);
    chk({7'h00, nmi}, 8'h00);
    wr(NSC_MASK_ADDR, 8'h00);
    wr(NSC_STATUS_ADDR, 8'h04);
    perr_n = 1'b0; cyc(1); perr_n = 1'b1; cyc(4);
    rs(8'h04);
    chk({7'h00, nmi}, 8'h00);
    wr(NSC_STATUS_ADDR, 8'h00);
    rs(8'h00);
  endtask : t_perr
  task automatic t_iochk();
    iochk_n = 1'b0; cyc(4);
    rs(8'h40);
    wr(NSC_STATUS_ADDR, 8'h08);
    rs(8'h08);
    iochk_n = 1'b1; cyc(3);
    wr(NSC_STATUS_ADDR, 8'h00);
    rs(8'h00);
  endtask : t_iochk
  task automatic t_misc();
    refr = 1'b1; cyc(1); refr = 1'b0;
    serr = 1'b1; cyc(2);
    chk({7'h00, nmi}, 8'h01);
    rs(8'h10);
    serr = 1'b0;
  endtask : t_misc
  initial begin
    repeat (10) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    t_ctrl(); t_perr(); t_iochk(); t_misc();
    summarize();
  end
  initial begin #200000; miscompares++; summarize(); end
endmodule : tb_nmi_status_speaker_control
